// ### verilog/bidir_port.sv
// 8-bit bidirectional port with pull-ups, change detect and sleep wake-up
//
// What this block does
// RQ1 - setting a direction bit puts that pin driver in high impedance
// RQ2 - clearing a direction bit drives the pin from its output latch
// RQ3 - weak pull-up per pin, those of input pins enabled when option bit 7 is cleared
// RQ4 - pull-up of any pin configured as output is always off
// RQ5 - power-on reset disables all pull-ups
// RQ6 - only pins 7..4 compare, output-configured ones are excluded
// RQ7 - every port read captures upper nibble; inputs compared continuously
// RQ8 - per-pin mismatches ORed set the change flag, control bit 0
// RQ9 - pending change interrupt wakes the device from sleep
// RQ10 - any port read or write refreshes the snapshot, ending mismatch
// RQ11 - persisting mismatch keeps setting flag; software accesses port then clears
// RQ12 - change coinciding with read at second phase may not set flag
// RQ13 - software should not poll the port while using change interrupts
// RQ14 - wake in crystal or low-power modes waits 1024 osc periods, not rc
// RQ15 - after wake branch to 0004h if global enable set, else in line
// RQ16 - reset sets all direction bits so pins start as inputs
`timescale 1ns/10ps
module bidir_port #(
    parameter bit Q2_RACE = 1'b1
) (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // port pins
    input  wire logic [7:0]  PIN_IN,
    output logic      [7:0]  PIN_OUT,
    output logic      [7:0]  PIN_OE,
    output logic      [7:0]  PULLUP_EN,
    // core side
    output logic             IRQ,
    output logic             SLEEPING,
    output logic             RESUME,
    output logic             RESUME_BRANCH,
    output logic      [12:0] RESUME_ADDR
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    localparam int OST_W_L = port_pkg::OST_W;

    logic [7:0]          sync1_reg;
    logic [7:0]          pins_reg;
    port_pkg::phase_e    phase_reg;
    logic [7:0]          port_data_reg;
    logic [7:0]          port_direction_reg;
    logic                pullup_enable_n;
    logic                global_int_enable;
    logic                change_int_enable;
    logic                port_change_flag;
    logic [1:0]          stat_reg;
    logic [1:0]          mask_reg;
    logic [1:0]          osc_reg;
    logic [3:0]          snap_reg;
    port_pkg::power_e    pwr_reg;
    logic [OST_W_L-1:0]  ost_cnt_reg;
    logic [31:0]         prdata_reg;
    logic                branch_reg;
    logic [12:0]         addr_reg;
    logic                access;
    logic                wr;
    logic                port_acc;
    logic                hide;
    logic                chg_set;
    logic                wake;
    logic                flag_next;
    logic [31:0]         rd_data;

    function automatic logic [3:0] mism(input logic [7:0] pins, input logic [3:0] snap,
                                        input logic [7:0] dir);
        mism = (pins[7:4] ^ snap) & dir[7:4];
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == port_pkg::ADDR_PORT)   || (a == port_pkg::ADDR_DIR)  ||
                    (a == port_pkg::ADDR_OPTION) || (a == port_pkg::ADDR_INTCTL) ||
                    (a == port_pkg::ADDR_STAT)   || (a == port_pkg::ADDR_MASK) ||
                    (a == port_pkg::ADDR_PWR);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser and phase counter

    always_ff @(posedge CLK) begin
        sync1_reg <= PIN_IN;
        pins_reg  <= sync1_reg;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            phase_reg <= port_pkg::PH_Q1;
        end else begin
            case (phase_reg)
                port_pkg::PH_Q1: phase_reg <= port_pkg::PH_Q2;
                port_pkg::PH_Q2: phase_reg <= port_pkg::PH_Q3;
                port_pkg::PH_Q3: phase_reg <= port_pkg::PH_Q4;
                default:         phase_reg <= port_pkg::PH_Q1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    assign access   = PSEL && PENABLE;
    assign wr       = access && PWRITE && is_mapped(PADDR);
    assign port_acc = access && (PADDR == port_pkg::ADDR_PORT);
    assign PREADY   = 1'b1;
    assign PSLVERR  = access && !is_mapped(PADDR);
    assign PRDATA   = prdata_reg;

    always_comb begin
        rd_data = 32'h0;
        case (PADDR)
            port_pkg::ADDR_PORT:   rd_data[7:0] = pins_reg;
            port_pkg::ADDR_DIR:    rd_data[7:0] = port_direction_reg;
            port_pkg::ADDR_OPTION: rd_data[port_pkg::OPT_PU_N_BIT] = pullup_enable_n;
            port_pkg::ADDR_INTCTL: begin
                rd_data[port_pkg::IC_FLAG_BIT] = port_change_flag;
                rd_data[port_pkg::IC_CIE_BIT]  = change_int_enable;
                rd_data[port_pkg::IC_GIE_BIT]  = global_int_enable;
            end
            port_pkg::ADDR_STAT:   rd_data[1:0] = stat_reg;
            port_pkg::ADDR_MASK:   rd_data[1:0] = mask_reg;
            port_pkg::ADDR_PWR: begin
                rd_data[port_pkg::PWR_SLEEP_BIT] = (pwr_reg != port_pkg::PWR_RUN);
                rd_data[port_pkg::PWR_OSC_LSB +: 2] = osc_reg;
            end
            default:               rd_data = 32'h0;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            prdata_reg <= 32'h0;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            prdata_reg <= rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // port configuration registers

    always_ff @(posedge CLK) begin
        if (RST) begin
            port_data_reg      <= port_pkg::LATCH_RST;
            port_direction_reg <= port_pkg::DIR_RST;    // [RQ16]
            pullup_enable_n    <= port_pkg::PU_N_RST;   // [RQ5]
            global_int_enable  <= 1'b0;
            change_int_enable  <= 1'b0;
            mask_reg           <= port_pkg::MASK_RST;
            osc_reg            <= port_pkg::OSC_RST;
        end else if (wr) begin
            case (PADDR)
                port_pkg::ADDR_PORT:   port_data_reg      <= PWDATA[7:0];
                port_pkg::ADDR_DIR:    port_direction_reg <= PWDATA[7:0];
                port_pkg::ADDR_OPTION: pullup_enable_n    <= PWDATA[port_pkg::OPT_PU_N_BIT];
                port_pkg::ADDR_INTCTL: begin
                    global_int_enable <= PWDATA[port_pkg::IC_GIE_BIT];
                    change_int_enable <= PWDATA[port_pkg::IC_CIE_BIT];
                end
                port_pkg::ADDR_MASK:   mask_reg <= PWDATA[1:0];
                port_pkg::ADDR_PWR:    osc_reg  <= PWDATA[port_pkg::PWR_OSC_LSB +: 2];
                default:               mask_reg <= mask_reg;
            endcase
        end
    end

    // pin drivers and pull-ups
    assign PIN_OE    = ~port_direction_reg;                                 // [RQ1] [RQ2]
    assign PIN_OUT   = port_data_reg;                                       // [RQ2]
    assign PULLUP_EN = port_direction_reg & {8{~pullup_enable_n}};          // [RQ3] [RQ4]

    ////////////////////////////////////////////////////////////////////////////
    // change detection

    // read-race at second phase may swallow a change
    assign hide    = Q2_RACE && port_acc && (phase_reg == port_pkg::PH_Q2);   // [RQ12]
    assign chg_set = (|mism(pins_reg, snap_reg, port_direction_reg)) && !hide; // [RQ6] [RQ8] [RQ11]
    // set wins over a software clear
    assign flag_next = chg_set || (port_change_flag &&
                       !(wr && PADDR == port_pkg::ADDR_INTCTL && !PWDATA[port_pkg::IC_FLAG_BIT]));

    always_ff @(posedge CLK) begin
        if (RST) begin
            snap_reg <= 4'h0;
        end else if (port_acc && !PSLVERR) begin
            snap_reg <= pins_reg[7:port_pkg::NIBBLE_LSB];                    // [RQ7] [RQ10]
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            port_change_flag <= 1'b0;
        end else begin
            port_change_flag <= flag_next;                                   // [RQ8] [RQ11]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status, w1c with set priority

    always_ff @(posedge CLK) begin
        if (RST) begin
            stat_reg <= 2'h0;
        end else begin
            stat_reg[port_pkg::STAT_CHG_BIT] <= chg_set ||
                (stat_reg[port_pkg::STAT_CHG_BIT] &&
                 !(wr && PADDR == port_pkg::ADDR_STAT && PWDATA[port_pkg::STAT_CHG_BIT]));
            stat_reg[port_pkg::STAT_WAKE_BIT] <= wake ||
                (stat_reg[port_pkg::STAT_WAKE_BIT] &&
                 !(wr && PADDR == port_pkg::ADDR_STAT && PWDATA[port_pkg::STAT_WAKE_BIT]));
        end
    end

    assign IRQ = |(stat_reg & mask_reg);

    ////////////////////////////////////////////////////////////////////////////
    // sleep and wake-up sequencing

    assign wake = (pwr_reg == port_pkg::PWR_SLEEP) && port_change_flag &&    // [RQ9]
                  change_int_enable;

    always_ff @(posedge CLK) begin
        if (RST) begin
            pwr_reg     <= port_pkg::PWR_RUN;
            ost_cnt_reg <= '0;
        end else begin
            case (pwr_reg)
                port_pkg::PWR_RUN: begin
                    if (wr && PADDR == port_pkg::ADDR_PWR && PWDATA[port_pkg::PWR_SLEEP_BIT]) begin
                        pwr_reg <= port_pkg::PWR_SLEEP;
                    end
                end
                port_pkg::PWR_SLEEP: begin
                    if (wake && osc_reg == port_pkg::OSC_RC) begin
                        pwr_reg <= port_pkg::PWR_RESUME;                     // [RQ14]
                    end else if (wake) begin
                        pwr_reg     <= port_pkg::PWR_OST;                    // [RQ9]
                        ost_cnt_reg <= OST_W_L'(port_pkg::OST_CYCLES - 1);   // [RQ14]
                    end
                end
                port_pkg::PWR_OST: begin
                    if (ost_cnt_reg == '0) begin
                        pwr_reg <= port_pkg::PWR_RESUME;
                    end else begin
                        ost_cnt_reg <= ost_cnt_reg - 1'b1;                   // [RQ14]
                    end
                end
                default: pwr_reg <= port_pkg::PWR_RUN;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            branch_reg <= 1'b0;
            addr_reg   <= 13'h0;
        end else if (pwr_reg != port_pkg::PWR_RESUME) begin
            branch_reg <= global_int_enable;                                 // [RQ15]
            addr_reg   <= global_int_enable ? port_pkg::VECTOR_ADDR : 13'h0; // [RQ15]
        end
    end

    assign SLEEPING      = (pwr_reg != port_pkg::PWR_RUN);
    assign RESUME        = (pwr_reg == port_pkg::PWR_RESUME);
    assign RESUME_BRANCH = branch_reg;
    assign RESUME_ADDR   = addr_reg;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence enter_ost_s;
        pwr_reg == port_pkg::PWR_SLEEP && wake && osc_reg != port_pkg::OSC_RC;
    endsequence

    sequence ost_done_s;
        pwr_reg == port_pkg::PWR_OST && ost_cnt_reg == '0;
    endsequence

    drive_dir_a: assert property (!port_direction_reg[0] |-> // [RQ2]
        PIN_OE[0] && PIN_OUT[0] == port_data_reg[0])
        else $error("pin 0 not driven from latch");
    pullup_out_a: assert property (|(PULLUP_EN & ~port_direction_reg) == 1'b0) // [RQ4]
        else $error("pull-up on output pin");
    pullup_en_a: assert property ($past(wr) && $past(PADDR) == port_pkg::ADDR_OPTION |-> // [RQ3]
        PULLUP_EN == (port_direction_reg & {8{~$past(PWDATA[port_pkg::OPT_PU_N_BIT])}}))
        else $error("pull-up enable not applied");
    por_pullup_a: assert property (disable iff (1'b0) $past(RST) |-> // [RQ5]
        PULLUP_EN == 8'h00 && PIN_OE == 8'h00)
        else $error("pull-ups or drivers on after reset");
    snap_refresh_a: assert property (port_acc && !PSLVERR |=> snap_reg == $past(pins_reg[7:4])) // [RQ10]
        else $error("snapshot not refreshed on port access");
    flag_cause_a: assert property ($rose(port_change_flag) |-> // [RQ8]
        $past(|mism(pins_reg, snap_reg, port_direction_reg)))
        else $error("flag set without input mismatch");
    mism_persist_a: assert property (chg_set |=> port_change_flag [*1]) // [RQ11]
        else $error("mismatch did not set flag");
    q2_race_a: assert property (hide && !port_change_flag |=> !port_change_flag) // [RQ12]
        else $error("flag set during second-phase read race");
    wake_ost_a: assert property (enter_ost_s |=> pwr_reg == port_pkg::PWR_OST [*8]) // [RQ14]
        else $error("startup delay cut short");
    ost_end_a: assert property (ost_done_s |=> RESUME ##1 !SLEEPING) // [RQ9]
        else $error("no resume after startup delay");
    rc_wake_a: assert property (wake && osc_reg == port_pkg::OSC_RC |=> RESUME) // [RQ14]
        else $error("rc mode should skip startup delay");
    vector_a: assert property (RESUME && RESUME_BRANCH |-> RESUME_ADDR == port_pkg::VECTOR_ADDR) // [RQ15]
        else $error("wrong wake vector");

endmodule

// ### verilog/port_pkg.sv
// constants and types shared by the bidirectional port with change wake
package port_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] ADDR_PORT   = 8'h00;
    localparam logic [7:0] ADDR_DIR    = 8'h04;
    localparam logic [7:0] ADDR_OPTION = 8'h08;
    localparam logic [7:0] ADDR_INTCTL = 8'h0c;
    localparam logic [7:0] ADDR_STAT   = 8'h10;
    localparam logic [7:0] ADDR_MASK   = 8'h14;
    localparam logic [7:0] ADDR_PWR    = 8'h18;
    // field positions
    localparam int OPT_PU_N_BIT  = 7;
    localparam int IC_FLAG_BIT   = 0;
    localparam int IC_CIE_BIT    = 3;
    localparam int IC_GIE_BIT    = 7;
    localparam int STAT_CHG_BIT  = 0;
    localparam int STAT_WAKE_BIT = 1;
    localparam int PWR_SLEEP_BIT = 0;
    localparam int PWR_OSC_LSB   = 1;
    localparam int NIBBLE_LSB    = 4;
    // reset values
    localparam logic [7:0] DIR_RST   = 8'hff;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic       PU_N_RST  = 1'b1;
    localparam logic [1:0] MASK_RST  = 2'h0;
    localparam logic [1:0] OSC_RST   = 2'h1;
    // oscillator modes
    localparam logic [1:0] OSC_LP = 2'h0;
    localparam logic [1:0] OSC_XT = 2'h1;
    localparam logic [1:0] OSC_HS = 2'h2;
    localparam logic [1:0] OSC_RC = 2'h3;
    // timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int OSC_PERIOD_PS = 4000;
    localparam int OST_PERIODS   = 1024;
    localparam int OST_CYCLES    =
        (OST_PERIODS * OSC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int OST_W         = 11;
    localparam logic [12:0] VECTOR_ADDR = 13'h0004;
    // four-phase instruction cycle
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b11,
        PH_Q4 = 2'b10
    } phase_e;
    // power state
    typedef enum logic [1:0] {
        PWR_RUN    = 2'b00,
        PWR_SLEEP  = 2'b01,
        PWR_OST    = 2'b11,
        PWR_RESUME = 2'b10
    } power_e;
endpackage

// ### test/keypad_model.sv
// keypad model: keys pull pins low, resolves the level seen on each pin
`timescale 1ns/10ps
module keypad_model (
    // clock
    input  wire logic       clk,
    // port side
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pullup_en,
    // keys held down by the bench
    input  wire logic [7:0] keys_down,
    output logic      [7:0] pin_level
);
    logic [7:0] float_reg;

    ////////////////////////////////////////////////////////////////////////////
    // undriven pins wander so a stale level never passes
    initial float_reg = 8'h5a;
    always @(posedge clk) begin
        float_reg <= ~float_reg;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) begin
                pin_level[i] = pin_out[i];
            end else if (keys_down[i]) begin
                pin_level[i] = 1'b0;
            end else if (pullup_en[i]) begin
                pin_level[i] = 1'b1;
            end else begin
                pin_level[i] = float_reg[i];
            end
        end
    end
endmodule

// ### test/bidir_port_with_change_wake_test.sv
// self-checking bench for the bidirectional port with change wake-up
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
    $display("mismatch at %0t: got %0h exp %0h", $time, (a), (e)); end end
module bidir_port_with_change_wake_test;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq, err, g;
    logic        sleeping, resume, resume_branch;
    logic [7:0]  paddr, pin_in, pin_out, pin_oe, pullup_en, keys, d, l;
    logic [31:0] pwdata, prdata, rd;
    logic [12:0] resume_addr;
    logic [1:0]  modes [4] = '{port_pkg::OSC_RC, port_pkg::OSC_XT,
                               port_pkg::OSC_LP, port_pkg::OSC_HS};
    int          error_cnt, compares, cyc, n;

    bidir_port u_dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PIN_IN(pin_in), .PIN_OUT(pin_out),
        .PIN_OE(pin_oe), .PULLUP_EN(pullup_en), .IRQ(irq), .SLEEPING(sleeping),
        .RESUME(resume), .RESUME_BRANCH(resume_branch), .RESUME_ADDR(resume_addr));
    keypad_model u_keys (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_en(pullup_en), .keys_down(keys), .pin_level(pin_in));

    ////////////////////////////////////////////////////////////////////////////
    initial clk = 1'b0;
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // snapshot refresh, then flag and status clear, writing the enables from ic
    task automatic rearm(input logic [31:0] ic);
        apb(1'b0, port_pkg::ADDR_PORT, 32'h0);
        apb(1'b1, port_pkg::ADDR_INTCTL, ic);
        apb(1'b1, port_pkg::ADDR_STAT, 32'h3);
    endtask

    function automatic logic [7:0] pu_exp(logic [7:0] dir, logic pu_n);
        return pu_n ? 8'h00 : dir;
    endfunction

    function automatic logic wait_ok(logic [1:0] m, int cnt);
        if (m == port_pkg::OSC_RC) return cnt <= 8;
        return cnt >= port_pkg::OST_CYCLES && cnt <= port_pkg::OST_CYCLES + 10;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; keys = 8'h00; cyc = 0; error_cnt = 0; compares = 0;
        void'($urandom(10));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        `CHK(pin_oe, 8'h00)
        `CHK(pullup_en, 8'h00)
        apb(1'b0, port_pkg::ADDR_DIR, 32'h0);
        `CHK(rd[7:0], port_pkg::DIR_RST)
        apb(1'b0, port_pkg::ADDR_OPTION, 32'h0);
        `CHK(rd[port_pkg::OPT_PU_N_BIT], 1'b1)
        apb(1'b0, 8'h20, 32'h0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0)
        $display("test reset done");

        repeat (8) begin
            d = 8'($urandom);
            l = 8'($urandom);
            g = 1'($urandom);
            apb(1'b1, port_pkg::ADDR_PORT, {24'h0, l});
            apb(1'b1, port_pkg::ADDR_DIR, {24'h0, d});
            apb(1'b1, port_pkg::ADDR_OPTION, {24'h0, g, 7'h0});
            @(negedge clk);
            `CHK(pin_oe, ~d)
            `CHK(pin_out, l)
            `CHK(pullup_en, pu_exp(d, g))
        end
        $display("test direction done");

        apb(1'b1, port_pkg::ADDR_DIR, 32'hff);
        apb(1'b1, port_pkg::ADDR_OPTION, 32'h0);
        apb(1'b1, port_pkg::ADDR_MASK, 32'h1);
        repeat (4) @(posedge clk);
        rearm(32'h88);
        @(posedge clk);
        keys <= 8'h01;
        repeat (6) @(posedge clk);
        apb(1'b0, port_pkg::ADDR_INTCTL, 32'h0);
        `CHK(rd[0], 1'b0)
        @(posedge clk);
        keys <= 8'h11;
        repeat (6) @(posedge clk);
        apb(1'b0, port_pkg::ADDR_INTCTL, 32'h0);
        `CHK(rd[0], 1'b1)
        @(negedge clk);
        `CHK(irq, 1'b1)
        apb(1'b1, port_pkg::ADDR_INTCTL, 32'h88);
        apb(1'b0, port_pkg::ADDR_INTCTL, 32'h0);
        `CHK(rd[0], 1'b1)
        apb(1'b1, port_pkg::ADDR_MASK, 32'h0);
        @(negedge clk);
        `CHK(irq, 1'b0)
        apb(1'b1, port_pkg::ADDR_MASK, 32'h1);
        rearm(32'h88);
        `CHK(rd[7:0], 8'hee)
        apb(1'b0, port_pkg::ADDR_INTCTL, 32'h0);
        `CHK(rd[0], 1'b0)
        @(negedge clk);
        `CHK(irq, 1'b0)
        @(posedge clk);
        keys <= 8'h00;
        repeat (4) @(posedge clk);
        rearm(32'h88);
        // pin 7 driven low against a high snapshot must not flag
        apb(1'b1, port_pkg::ADDR_PORT, 32'h0);
        apb(1'b1, port_pkg::ADDR_DIR, 32'h7f);
        repeat (6) @(posedge clk);
        apb(1'b0, port_pkg::ADDR_INTCTL, 32'h0);
        `CHK(rd[0], 1'b0)
        apb(1'b1, port_pkg::ADDR_DIR, 32'hff);
        repeat (6) @(posedge clk);
        $display("test change done");

        foreach (modes[i]) begin
            g = 1'(i);
            rearm({24'h0, g, 7'h08});
            apb(1'b1, port_pkg::ADDR_PWR, {29'h0, modes[i], 1'b0});
            apb(1'b1, port_pkg::ADDR_PWR, {29'h0, modes[i], 1'b1});
            @(negedge clk);
            `CHK(sleeping, 1'b1)
            // no port polling while asleep
            @(posedge clk);
            keys <= 8'h20;
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (resume !== 1'b1 && n < 2000);
            `CHK(wait_ok(modes[i], n), 1'b1)
            `CHK(resume_branch, g)
            `CHK(resume_addr, g ? port_pkg::VECTOR_ADDR : 13'h0000)
            repeat (3) @(posedge clk);
            apb(1'b0, port_pkg::ADDR_STAT, 32'h0);
            `CHK(rd[port_pkg::STAT_WAKE_BIT], 1'b1)
            @(posedge clk);
            keys <= 8'h00;
            repeat (4) @(posedge clk);
        end
        $display("test wake done");
        end_of_test();
    end
endmodule
